// ---- common/rio_pkg.sv ----
package rio_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int WIN_W  = 2;
    localparam int BASE_W = ADDR_W - WIN_W;

    // ------------------------------------------------------------
    // register offsets inside the four-byte window
    // ------------------------------------------------------------
    localparam logic [WIN_W-1:0] OFS_RELAY   = 2'h0;
    localparam logic [WIN_W-1:0] OFS_INPUT   = 2'h1;
    localparam logic [WIN_W-1:0] OFS_SPARE_A = 2'h2;
    localparam logic [WIN_W-1:0] OFS_SPARE_B = 2'h3;

    // ------------------------------------------------------------
    // reset and idle values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RELAY_RST = 8'h00;
    localparam logic [DATA_W-1:0] IDLE_DATA = 8'hff;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              aen;
        logic              ior_b;
        logic              iow_b;
        logic [DATA_W-1:0] data;
    } rio_bus_type;

    typedef enum logic [1:0] {SEL_NONE, SEL_RELAY, SEL_INPUT, SEL_SPARE} rio_sel_type;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} rio_state_type;

endpackage

// ---- hw/rio_port.sv ----
`timescale 1ns/1ps

// Contract
// [RL1] four-byte window, only offsets zero and one
// [RL2] base aligned, address bits one:zero select register
// [RL3] offset one read returns all inputs
// [RL4] input bit n is channel n
// [RL5] input bit one means energized
// [RL6] reset clears relay latch, relays off
// [RL7] offset zero read returns relay latch
// [RL8] offset zero write loads all relay bits
// [RL9] relay bit n drives relay n, one energizes
// [RL10] energized closes normally open, opens normally closed
// [RL11] host does read, or, write for changes
// [RL12] offsets two, three ignore writes, drive nothing
module rio_port
    import rio_pkg::*;
#(
    parameter int N_CH = 8
)
(
    input  wire logic              i_mclk,
    input  wire logic              i_rst_b,
    input  wire rio_bus_type       i_bus,
    input  wire logic [BASE_W-1:0] i_base_sel,
    input  wire logic [N_CH-1:0]   i_input_ch,
    output logic      [DATA_W-1:0] o_sd,
    output logic                   o_sd_oe_b,
    output logic      [N_CH-1:0]   o_relay_ch,
    output logic      [N_CH-1:0]   o_no_closed,
    output logic      [N_CH-1:0]   o_nc_closed
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (N_CH < 1 || N_CH > DATA_W) begin : g_bad_width
        $error("rio_port: N_CH must lie between 1 and the data width");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] to_byte(input logic [N_CH-1:0] v);
        logic [DATA_W-1:0] b;
        b          = '0;
        b[N_CH-1:0] = v;
        return b;
    endfunction

    function automatic logic readable(input rio_sel_type s);
        return (s == SEL_RELAY) || (s == SEL_INPUT);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rio_state_type     state_q;
    rio_state_type     state_d;
    logic [N_CH-1:0]   relay_q;
    logic [N_CH-1:0]   relay_d;
    logic [DATA_W-1:0] sd_q;
    logic [DATA_W-1:0] sd_d;
    logic              sd_oe_b_q;
    logic              sd_oe_b_d;
    logic [N_CH-1:0]   no_q;
    logic [N_CH-1:0]   no_d;
    logic [N_CH-1:0]   nc_q;
    logic [N_CH-1:0]   nc_d;
    rio_sel_type       sel;
    logic [DATA_W-1:0] rd_data;
    logic              wr_relay;

    // ------------------------------------------------------------
    // address window decode
    // ------------------------------------------------------------
    rio_win_dec u_dec (
        .i_addr     (i_bus.addr),
        .i_aen      (i_bus.aen),
        .i_base_sel (i_base_sel),
        .o_sel      (sel)
    );

    // ------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------
    always_comb begin
        if (sel == SEL_RELAY) begin
            rd_data = to_byte(relay_q);  // RL7
        end else if (sel == SEL_INPUT) begin
            rd_data = to_byte(i_input_ch);  // RL3 RL4 RL5
        end else begin
            rd_data = IDLE_DATA;
        end
    end

    // ------------------------------------------------------------
    // bus cycle sequencing and relay latch
    // ------------------------------------------------------------
    always_comb begin
        state_d   = state_q;
        relay_d   = relay_q;
        sd_d      = IDLE_DATA;
        sd_oe_b_d = 1'b1;
        case (state_q)
            ST_IDLE: begin
                if (!i_bus.iow_b && sel != SEL_NONE) begin
                    // one load per strobe; spare offsets swallow the write
                    if (sel == SEL_RELAY) begin
                        relay_d = i_bus.data[N_CH-1:0];  // RL8 RL9
                    end
                    state_d = ST_WRITE;  // RL12
                end else if (!i_bus.ior_b && readable(sel)) begin
                    sd_d      = rd_data;
                    sd_oe_b_d = 1'b0;
                    state_d   = ST_READ;
                end
            end
            ST_READ: begin
                // data follows the live source while the strobe is held
                if (i_bus.ior_b || !readable(sel)) begin
                    state_d = ST_IDLE;
                end else begin
                    sd_d      = rd_data;
                    sd_oe_b_d = 1'b0;
                end
            end
            ST_WRITE: begin
                if (i_bus.iow_b) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // contact state
    // ------------------------------------------------------------
    always_comb begin
        no_d = relay_d;   // RL10
        nc_d = ~relay_d;  // RL10
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            state_q   <= ST_IDLE;
            relay_q   <= RELAY_RST[N_CH-1:0];  // RL6
            sd_q      <= IDLE_DATA;
            sd_oe_b_q <= 1'b1;
            no_q      <= RELAY_RST[N_CH-1:0];
            nc_q      <= ~RELAY_RST[N_CH-1:0];
        end else begin
            state_q   <= state_d;
            relay_q   <= relay_d;
            sd_q      <= sd_d;
            sd_oe_b_q <= sd_oe_b_d;
            no_q      <= no_d;
            nc_q      <= nc_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_sd        = sd_q;
    assign o_sd_oe_b   = sd_oe_b_q;
    assign o_relay_ch  = relay_q;  // RL9
    assign o_no_closed = no_q;
    assign o_nc_closed = nc_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // the only taken write that may move the relay latch
    assign wr_relay = (state_q == ST_IDLE) && !i_bus.iow_b && (sel == SEL_RELAY);

    default clocking cb @(posedge i_mclk);
    endclocking

    default disable iff (!i_rst_b);

    a_reset_relays_off: // RL6
    assert property (@(posedge i_mclk) disable iff (1'b0)
        !i_rst_b |=> (o_relay_ch == '0) && (o_nc_closed == '1) && (o_no_closed == '0))
    else $error("relays not de-energized after reset");

    a_window_hit_align: // RL2
    assert property ((sel != SEL_NONE) |->
        (i_bus.addr[ADDR_W-1:WIN_W] == i_base_sel) && !i_bus.aen)
    else $error("window hit outside the aligned base");

    a_spare_no_write: // RL12
    assert property ((state_q == ST_IDLE) && !i_bus.iow_b
        && (i_bus.addr[WIN_W-1:0] >= OFS_SPARE_A) |=> $stable(o_relay_ch))
    else $error("spare offset write altered the relay latch");

    a_spare_no_drive: // RL1
    assert property ((state_q == ST_IDLE) && i_bus.iow_b && !readable(sel)
        |=> o_sd_oe_b)
    else $error("data bus driven for an unused or foreign address");

    a_relay_write_load: // RL8
    assert property ((state_q == ST_IDLE) && !i_bus.iow_b && (sel == SEL_RELAY)
        |=> (o_relay_ch == $past(i_bus.data[N_CH-1:0]))
            && (o_no_closed == $past(i_bus.data[N_CH-1:0])))
    else $error("relay latch did not take the written byte");

    a_one_load_strobe: // RL9
    assert property ((state_q == ST_WRITE) && !i_bus.iow_b
        |=> $stable(o_relay_ch) [*2])
    else $error("relay latch changed while a write strobe was held");

    a_relay_change_cause: // RL9
    assert property (!$stable(o_relay_ch) |->
        $past(wr_relay) || !$past(i_rst_b))
    else $error("relay outputs changed without a latch write");

    a_input_read_byte: // RL3
    assert property ((state_q == ST_IDLE) && i_bus.iow_b && !i_bus.ior_b
        && (sel == SEL_INPUT)
        |=> !o_sd_oe_b && (o_sd == to_byte($past(i_input_ch))))
    else $error("input byte read returned wrong data");

    a_relay_readback: // RL7
    assert property ((state_q == ST_IDLE) && i_bus.iow_b && !i_bus.ior_b
        && (sel == SEL_RELAY)
        |=> !o_sd_oe_b && (o_sd == to_byte($past(o_relay_ch))))
    else $error("relay readback returned wrong data");

    a_read_release: // RL12
    assert property ((state_q == ST_READ) && i_bus.ior_b |=> o_sd_oe_b && (o_sd == IDLE_DATA))
    else $error("data bus not released after read strobe");

    a_contacts_match: // RL10
    assert property ((o_no_closed == o_relay_ch) && (o_nc_closed == ~o_relay_ch))
    else $error("contact state disagrees with relay drive");

    a_bit_per_channel: // RL4
    assert property ((state_q == ST_READ) && !i_bus.ior_b && (sel == SEL_INPUT)
        && $stable(i_input_ch) |=> o_sd[0] == $past(i_input_ch[0]))
    else $error("input channel zero not on data bit zero");

    a_window_miss_quiet: // RL2
    assert property (i_bus.aen || (i_bus.addr[ADDR_W-1:WIN_W] != i_base_sel)
        |=> o_sd_oe_b && $stable(o_relay_ch))
    else $error("foreign address moved the relays or the data bus");

    a_read_tracks_input: // RL3
    assert property ((state_q == ST_READ) && !i_bus.ior_b && (sel == SEL_INPUT)
        |=> !o_sd_oe_b && (o_sd == to_byte($past(i_input_ch))))
    else $error("held input read did not follow the live inputs");

    a_top_bit_channel: // RL4
    assert property ((state_q == ST_IDLE) && i_bus.iow_b && !i_bus.ior_b
        && (sel == SEL_INPUT)
        |=> o_sd[N_CH-1] == $past(i_input_ch[N_CH-1]))
    else $error("top input channel not on its own data bit");

    a_write_wins: // RL8
    assert property ((state_q == ST_IDLE) && !i_bus.iow_b && !i_bus.ior_b
        && (sel != SEL_NONE) |=> o_sd_oe_b)
    else $error("data bus driven while a write strobe was taken");

    a_write_no_drive: // RL8
    assert property ((state_q == ST_WRITE) |=> o_sd_oe_b)
    else $error("data bus driven during a write cycle");

    a_write_exit_idle: // RL8
    assert property ((state_q == ST_WRITE) && i_bus.iow_b |=> (state_q == ST_IDLE))
    else $error("write cycle did not end after the strobe rose");

    a_idle_data_value: // RL12
    assert property (o_sd_oe_b |-> (o_sd == IDLE_DATA))
    else $error("undriven data bus shows a stale value");

    a_spare_read_quiet: // RL12
    assert property ((state_q == ST_IDLE) && !i_bus.ior_b && (sel == SEL_SPARE)
        |=> o_sd_oe_b && (o_sd == IDLE_DATA))
    else $error("spare offset read drove the data bus");

    a_read_addr_leave: // RL1
    assert property ((state_q == ST_READ) && !readable(sel) |=> o_sd_oe_b)
    else $error("data bus still driven after the address left the window");

    a_relay_hold_read: // RL7
    assert property ((state_q == ST_READ) |=> $stable(o_relay_ch))
    else $error("relay latch changed during a read cycle");

    a_relay_readback_hold: // RL7
    assert property ((state_q == ST_READ) && !i_bus.ior_b && (sel == SEL_RELAY)
        |=> !o_sd_oe_b && (o_sd == to_byte($past(o_relay_ch))))
    else $error("held relay readback returned wrong data");

    a_reset_bus_idle: // RL6
    assert property (@(posedge i_mclk) disable iff (1'b0)
        !i_rst_b |=> o_sd_oe_b && (o_sd == IDLE_DATA))
    else $error("data bus driven right after reset");

endmodule

// ---- hw/rio_win_dec.sv ----
`timescale 1ns/1ps

module rio_win_dec
    import rio_pkg::*;
(
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_aen,
    input  wire logic [BASE_W-1:0] i_base_sel,
    output rio_sel_type            o_sel
);

    // ------------------------------------------------------------
    // window hit and register select
    // ------------------------------------------------------------
    logic hit;

    assign hit = !i_aen && (i_addr[ADDR_W-1:WIN_W] == i_base_sel);  // RL2

    always_comb begin
        if (!hit) begin
            o_sel = SEL_NONE;
        end else if (i_addr[WIN_W-1:0] == OFS_RELAY) begin
            o_sel = SEL_RELAY;
        end else if (i_addr[WIN_W-1:0] == OFS_INPUT) begin
            o_sel = SEL_INPUT;
        end else begin
            o_sel = SEL_SPARE;  // RL1
        end
    end

endmodule

// ---- testbench/rio_host.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// host side of the i/o cycles
// ------------------------------------------------------------
module rio_host
    import rio_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic [DATA_W-1:0] i_sd,
    input  wire logic              i_sd_oe_b,
    output rio_bus_type            o_bus
);
    initial o_bus = '{addr: '0, aen: 1'b1, ior_b: 1'b1, iow_b: 1'b1, data: 8'h00};

    // released lines show the inverse of what they last carried
    task automatic io_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_mclk);
        o_bus <= '{addr: a, aen: 1'b0, ior_b: 1'b1, iow_b: 1'b0, data: d};
        @(posedge i_mclk);
        o_bus <= '{addr: ~a, aen: 1'b1, ior_b: 1'b1, iow_b: 1'b1, data: ~d};
    endtask

    // both strobes low so the write must win; the strobe outlives the taking edge
    task automatic io_wr_held(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                              input int hold, output logic oe_b);
        @(posedge i_mclk);
        o_bus <= '{addr: a, aen: 1'b0, ior_b: 1'b0, iow_b: 1'b0, data: d};
        @(posedge i_mclk);
        o_bus.data <= ~d;
        repeat (hold) @(posedge i_mclk);
        #1;
        oe_b = i_sd_oe_b;
        @(posedge i_mclk);
        o_bus <= '{addr: ~a, aen: 1'b1, ior_b: 1'b1, iow_b: 1'b1, data: d};
    endtask

    // hold stretches the read strobe for a slow host
    task automatic io_rd(input logic [ADDR_W-1:0] a, input int hold,
                         output logic [DATA_W-1:0] d, output logic oe_b);
        @(posedge i_mclk);
        o_bus <= '{addr: a, aen: 1'b0, ior_b: 1'b0, iow_b: 1'b1, data: o_bus.data};
        repeat (hold + 1) @(posedge i_mclk);
        #1;
        d = i_sd;
        oe_b = i_sd_oe_b;
        @(posedge i_mclk);
        o_bus <= '{addr: ~a, aen: 1'b1, ior_b: 1'b1, iow_b: 1'b1, data: ~o_bus.data};
    endtask

    // set bits without disturbing the others
    task automatic io_set(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m);
        logic [DATA_W-1:0] d;
        logic              oe_b;
        io_rd(a, 0, d, oe_b);
        io_wr(a, d | m);
    endtask
endmodule

// ---- testbench/tb_relay_output_isolated_input_port.sv ----
`timescale 1ns/1ps

module tb_relay_output_isolated_input_port;
    import rio_pkg::*;
    logic              i_mclk;
    logic              i_rst_b;
    rio_bus_type       bus;
    logic [BASE_W-1:0] base;
    logic [7:0]        ins;
    logic [7:0]        sd;
    logic              oe_b;
    logic [7:0]        relay;
    logic [7:0]        no_c;
    logic [7:0]        nc_c;
    logic [7:0]        mdl;
    logic [7:0]        d;
    logic              oe;
    int                fails;
    int                total_checks;
    int                seed;

    rio_port #(.N_CH(8)) dut_u (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_bus(bus), .i_base_sel(base),
        .i_input_ch(ins), .o_sd(sd), .o_sd_oe_b(oe_b), .o_relay_ch(relay),
        .o_no_closed(no_c), .o_nc_closed(nc_c)
    );

    rio_host host_u (.i_mclk(i_mclk), .i_sd(sd), .i_sd_oe_b(oe_b), .o_bus(bus));

    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic outs();
        chk("relay", mdl, relay);
        chk("no_closed", mdl, no_c);
        chk("nc_closed", ~mdl, nc_c);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end

    initial begin
        #400000;
        fails++;
        test_done();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        fails = 0;
        total_checks = 0;
        seed = 32'h27e9;
        base = BASE_W'($random(seed));
        ins = 8'h00;
        i_rst_b = 1'b0;
        mdl = RELAY_RST;
        repeat (3) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        @(posedge i_mclk);
        #1;
        outs();
        host_u.io_rd({base, OFS_RELAY}, 0, d, oe);
        chk("relay_rd", mdl, d);
        for (int i = 0; i < 16; i++) begin
            mdl = 8'($random(seed));
            host_u.io_wr({base, OFS_RELAY}, mdl);
            #1;
            outs();
            host_u.io_rd({base, OFS_RELAY}, i % 3, d, oe);
            chk("relay_rd", mdl, d);
            chk("relay_oe", 8'h00, {7'h0, oe});
            @(posedge i_mclk);
            ins <= (i < 8) ? (8'h01 << i) : 8'($random(seed));
            host_u.io_rd({base, OFS_INPUT}, i % 2, d, oe);
            chk("input_rd", ins, d);
        end
        for (int i = 2; i < 4; i++) begin
            host_u.io_wr({base, 2'(i)}, ~mdl);
            #1;
            outs();
            host_u.io_rd({base, 2'(i)}, 0, d, oe);
            chk("spare_oe", 8'h01, {7'h0, oe});
            chk("spare_rd", IDLE_DATA, d);
        end
        mdl = 8'($random(seed));
        host_u.io_wr_held({base, OFS_RELAY}, mdl, 2, oe);
        chk("both_oe", 8'h01, {7'h0, oe});
        #1;
        outs();
        host_u.io_wr({base ^ 8'h01, OFS_RELAY}, ~mdl);
        #1;
        outs();
        host_u.io_rd({base ^ 8'h80, OFS_INPUT}, 0, d, oe);
        chk("outside_oe", 8'h01, {7'h0, oe});
        chk("outside_rd", IDLE_DATA, d);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            mdl = mdl | d;
            host_u.io_set({base, OFS_RELAY}, d);
            #1;
            outs();
        end
        @(posedge i_mclk);
        i_rst_b <= 1'b0;
        @(posedge i_mclk);
        i_rst_b <= 1'b1;
        mdl = RELAY_RST;
        #1;
        outs();
        host_u.io_rd({base, OFS_RELAY}, 0, d, oe);
        chk("relay_rd", mdl, d);
        test_done();
    end
endmodule
